/* hdl/mm_bus_master_ctrl.sv */
// Master-side control and handshake logic for an on-chip memory-mapped bus.
// Assumes the fabric, arbiter and slaves run on the same clock as this block.
//
// Behaviour
// (RL1) Transfer incomplete until stall request drops.
// (RL2) Hold all control outputs while stalled.
// (RL3) Fabric drives stall while not ready.
// (RL4) Arbiter keeps grant while grant-hold stays high.
// (RL5) Grant-hold rises and falls with read/write.
// (RL6) Bursting build carries no grant-hold.
// (RL7) Arbiter ignores priority for grant-hold masters.
// (RL8) Grant-hold does not win arbitration itself.
// (RL9) Grant-hold is always released eventually.
// (RL10) Fabric flags valid read data cycles.
// (RL11) Returned read words qualified by valid flag.
// (RL12) Discard drops all earlier outstanding reads.
// (RL13) Burst length output never below one.
// (RL14) Burst length at most two power n-1.
// (RL15) Optional whole-system reset request output.
// (RL16) All signals active high here; reset_n is active low.
// (RL17) Fabric returns read data in order.
// (RL18) Read issued with discard survives it.
// (RL19) Count outstanding reads, clear on discard.
`include "mm_master_defines.svh"

module mm_bus_master_ctrl
  import mm_master_pkg::*;
#(
  parameter bit ENABLE_BURST = 1'b0
) (
  input  wire logic                   clock,
  input  wire logic                   reset_n,
  // User command side.
  input  wire logic                   cmd_valid,
  output wire logic                   cmd_ready,
  input  wire logic                   cmd_read,
  input  wire logic [`MM_ADDR_W-1:0]  cmd_addr,
  input  wire logic [`MM_DATA_W-1:0]  cmd_wdata,
  input  wire logic [`MM_BE_W-1:0]    cmd_be,
  input  wire logic [`MM_BURST_W-1:0] cmd_burst,
  input  wire logic                   cmd_lock,
  input  wire logic                   cmd_flush,
  input  wire logic                   sys_reset_req,
  // User response side.
  output logic                        rsp_valid,
  output logic [`MM_DATA_W-1:0]       rsp_data,
  output wire logic [`MM_CNT_W-1:0]   rd_pending,
  // Fabric side.
  output logic [`MM_ADDR_W-1:0]       address,
  output logic                        read,
  output logic                        write,
  output logic [`MM_DATA_W-1:0]       writedata,
  output logic [`MM_BE_W-1:0]         byteenable,
  output logic [`MM_BURST_W-1:0]      burstcount,
  output logic                        arbiterlock,
  output logic                        flush,
  output logic                        resetrequest,
  input  wire logic                   waitrequest,
  input  wire logic                   readdatavalid,
  input  wire logic [`MM_DATA_W-1:0]  readdata
);

  rd_track_if trk_bus ();

  bus_state_t                 state_q;
  bus_state_t                 state_d;
  logic                       seq_q;
  logic                       seq_d;
  logic                       lock_d;
  logic [`MM_LOCK_IDLE_W-1:0] idle_q;
  logic [`MM_LOCK_IDLE_W-1:0] idle_d;

  logic                       done;
  logic                       take;
  logic                       lock_timeout;
  logic                       lock_ok;
  logic [`MM_BURST_W-1:0]     burst_legal;

  // Clamp a requested burst length into the legal range.
  function automatic logic [`MM_BURST_W-1:0] clamp_burst(input logic [`MM_BURST_W-1:0] n);
    if (n < `MM_BURST_MIN) begin
      clamp_burst = `MM_BURST_MIN; // [RL13]
    end else if (n > `MM_BURST_MAX) begin
      clamp_burst = `MM_BURST_MAX; // [RL14]
    end else begin
      clamp_burst = n;
    end
  endfunction

  // A transfer ends only on an edge that sees the stall request low, and a new
  // command is taken then or while nothing is on the bus.
  assign done      = (state_q == ST_BUSY) && !waitrequest; // [RL1]
  assign cmd_ready = (state_q == ST_IDLE) || done;         // [RL1] [RL2]
  assign take      = cmd_valid && cmd_ready;

  // Grant-hold exists only in the non-bursting build, which fixes length at one; bursting builds
  // clamp the length and drop grant-hold instead. The choice is fixed at elaboration.
  assign lock_ok     = !ENABLE_BURST;                                          // [RL6]
  assign burst_legal = ENABLE_BURST ? clamp_burst(cmd_burst) : `MM_BURST_MIN; // [RL13] [RL14]

  // The held grant is dropped after a long run of unused cycles, so a user that
  // forgets to end a locked sequence cannot starve every other master.
  assign lock_timeout = seq_q && (state_q == ST_IDLE) && !take
                        && (idle_q == `MM_LOCK_IDLE_MAX); // [RL9]

  // Tracker hookup: a read counts when the fabric takes it, a flush likewise.
  assign trk_bus.read_taken  = done && read;  // [RL19]
  assign trk_bus.flush_taken = done && flush; // [RL12]
  assign rd_pending          = trk_bus.pending;

  // Next bus phase.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          state_d = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (done && !take) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Locked sequence tracking. A command with cmd_lock high says more locked
  // transfers follow; the first one with it low is the last of the sequence.
  always_comb begin
    seq_d  = seq_q;
    lock_d = arbiterlock;
    idle_d = `MM_LOCK_IDLE_ZERO;
    if (take) begin
      seq_d  = cmd_lock && lock_ok;
      lock_d = (cmd_lock || seq_q) && lock_ok; // [RL5] [RL8]
    end else if (lock_timeout) begin
      seq_d  = 1'b0;
      lock_d = 1'b0; // [RL9]
    end else if (done && !seq_q) begin
      lock_d = 1'b0; // [RL5]
    end else if (seq_q && state_q == ST_IDLE) begin
      idle_d = idle_q + `MM_LOCK_IDLE_ONE;
    end
  end

  // Bus phase and lock registers.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_q     <= ST_IDLE;
      seq_q       <= 1'b0;
      idle_q      <= `MM_LOCK_IDLE_ZERO;
      arbiterlock <= 1'b0;
    end else begin
      state_q     <= state_d;
      seq_q       <= seq_d;
      idle_q      <= idle_d;
      arbiterlock <= lock_d; // [RL5]
    end
  end

  // Strobes. They change only on take or completion, so a stalled transfer keeps
  // every control output steady.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      read  <= 1'b0;
      write <= 1'b0;
      flush <= 1'b0;
    end else if (take) begin
      read  <= cmd_read;
      write <= !cmd_read;
      flush <= cmd_flush; // [RL12]
    end else if (done) begin
      read  <= 1'b0; // [RL1]
      write <= 1'b0;
      flush <= 1'b0;
    end
  end

  // Address and data fields are loaded only when a command is taken.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      address    <= '0;
      writedata  <= '0;
      byteenable <= '0;
      burstcount <= `MM_BURST_MIN; // [RL13]
    end else if (take) begin
      address    <= cmd_addr; // [RL2]
      writedata  <= cmd_wdata;
      byteenable <= cmd_be;
      burstcount <= burst_legal;
    end
  end

  // Read responses are captured only when qualified by the tracker.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rsp_valid <= 1'b0;
      rsp_data  <= '0;
    end else begin
      rsp_valid <= trk_bus.rsp_take; // [RL11]
      if (trk_bus.rsp_take) begin
        rsp_data <= readdata;
      end
    end
  end

  // System reset request, registered; all pins here except reset_n are active high.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      resetrequest <= 1'b0;
    end else begin
      resetrequest <= sys_reset_req; // [RL15] [RL16]
    end
  end

  mm_read_tracker u_tracker (
    .clock         (clock),
    .reset_n       (reset_n),
    .readdatavalid (readdatavalid),
    .trk           (trk_bus.trk)
  );

endmodule

/* hdl/mm_master_defines.svh */
// Constants for the memory-mapped bus master control block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef MM_MASTER_DEFINES_SVH
`define MM_MASTER_DEFINES_SVH

// Bus widths.
`define MM_ADDR_W      32
`define MM_DATA_W      32
`define MM_BE_W        4
`define MM_BURST_W     11

// Burst length limits: at least one, at most two to the power of width minus one.
`define MM_BURST_MIN   11'h001
`define MM_BURST_MAX   11'h400

// Outstanding read counter.
`define MM_CNT_W       16
`define MM_CNT_ZERO    16'h0000
`define MM_CNT_ONE     16'h0001

// Idle cycles a held grant may stay unused before the block lets it go.
`define MM_LOCK_IDLE_W     8
`define MM_LOCK_IDLE_MAX   8'hFF
`define MM_LOCK_IDLE_ZERO  8'h00
`define MM_LOCK_IDLE_ONE   8'h01

`endif

/* hdl/mm_master_pkg.sv */
// Types shared by the memory-mapped bus master control block.
// Assumes mm_master_defines.svh is on the include path.
package mm_master_pkg;

  // Bus phase of the master: nothing on the bus, or a transfer being offered.
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } bus_state_t;

endpackage

/* hdl/mm_read_tracker.sv */
// Outstanding pipelined read counter with response qualification.
// Assumes the fabric returns responses in issue order and drops flushed ones.
`include "mm_master_defines.svh"

module mm_read_tracker (
  input  wire logic  clock,
  input  wire logic  reset_n,
  input  wire logic  readdatavalid,
  rd_track_if.trk    trk
);

  logic [`MM_CNT_W-1:0] count_q;
  logic [`MM_CNT_W-1:0] count_d;
  logic                 have_pending;
  logic [`MM_CNT_W-1:0] after_inc;

  // A response is only used while a read is known to be outstanding, and never in a
  // flush cycle, since anything arriving then answers a read that was cancelled.
  assign have_pending = (count_q != `MM_CNT_ZERO);
  assign trk.rsp_take = readdatavalid && have_pending && !trk.flush_taken; // [RL11] [RL12]
  assign trk.pending  = count_q;

  assign after_inc = trk.read_taken ? count_q + `MM_CNT_ONE : count_q; // [RL19]

  // A flush clears the count, but a read taken in that same cycle survives it.
  assign count_d = trk.flush_taken ? (trk.read_taken ? `MM_CNT_ONE : `MM_CNT_ZERO) // [RL18]
                 : (trk.rsp_take ? after_inc - `MM_CNT_ONE : after_inc);           // [RL19]

  // Counter register.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      count_q <= `MM_CNT_ZERO;
    end else begin
      count_q <= count_d;
    end
  end

endmodule

/* hdl/rd_track_if.sv */
// Carrier between the master control and its outstanding read tracker.
// Assumes both ends run on the same bus clock.
`include "mm_master_defines.svh"

interface rd_track_if;
  logic                 read_taken;
  logic                 flush_taken;
  logic                 rsp_take;
  logic [`MM_CNT_W-1:0] pending;

  modport ctrl (output read_taken, output flush_taken, input rsp_take, input pending);
  modport trk  (input read_taken, input flush_taken, output rsp_take, output pending);
endinterface

/* tb/mm_bus_master_ctrl_assertions.sv */
// Port checks for the bus master control block.
// Assumes one bus clock and a synchronous active-low reset.
`include "mm_master_defines.svh"

module mm_bus_master_ctrl_assertions (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        sys_reset_req,
  input wire logic        waitrequest,
  input wire logic        readdatavalid,
  input wire logic        read,
  input wire logic        write,
  input wire logic        flush,
  input wire logic        arbiterlock,
  input wire logic        resetrequest,
  input wire logic        rsp_valid,
  input wire logic [31:0] address,
  input wire logic [10:0] burstcount,
  input wire logic [15:0] rd_pending
);
  timeunit 1ns;
  timeprecision 1ns;
  // All checks share the bus clock and are muted in reset.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire busy  = read | write;
  wire stall = busy & waitrequest;
  wire take  = busy & ~waitrequest;

  a_hold_stall: assert property (stall |=>
    $stable({read, write, flush, arbiterlock, address, burstcount})) else $error("moved in stall");
  a_stay_busy: assert property (stall |=> busy) else $error("left while stalled");
  a_burst_min: assert property (burstcount != 11'h000) else $error("burst zero");
  a_burst_max: assert property (burstcount <= `MM_BURST_MAX) else $error("burst big");
  a_lock_rise: assert property ($rose(arbiterlock) |-> busy) else $error("lock alone");
  a_reset_copy: assert property ($past(reset_n) |->
    resetrequest == $past(sys_reset_req)) else $error("reset request lag");
  a_rsp_qual: assert property (rsp_valid |->
    $past(readdatavalid) && $past(rd_pending) != 16'h0000) else $error("unqualified word");
  a_pend_inc: assert property (take && read && !flush && !readdatavalid |=>
    rd_pending == $past(rd_pending) + 16'h0001) else $error("count not raised");
  a_flush_clr: assert property (take && flush |=>
    rd_pending == {15'h0000, $past(read)}) else $error("flush count wrong");
  c_stall: cover property (stall && read);
  c_flush: cover property (take && flush && read);
  c_lock: cover property (arbiterlock && !busy);
endmodule

bind mm_bus_master_ctrl mm_bus_master_ctrl_assertions u_chk (
  .clock(clock), .reset_n(reset_n), .sys_reset_req(sys_reset_req),
  .waitrequest(waitrequest), .readdatavalid(readdatavalid), .read(read),
  .write(write), .flush(flush), .arbiterlock(arbiterlock), .resetrequest(resetrequest),
  .rsp_valid(rsp_valid), .address(address), .burstcount(burstcount), .rd_pending(rd_pending));

/* tb/mm_bus_master_ctrl_tb_top.sv */
// Self-checking bench for the bus master control block.
// Assumes the fabric model returns each read address xor a fixed mask.
module mm_bus_master_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, reset_n = 1'b0, cmd_valid = 1'b0, cmd_read = 1'b0;
  logic cmd_lock = 1'b0, cmd_flush = 1'b0, sys_reset_req = 1'b0, slow = 1'b0;
  logic [31:0] cmd_addr = 32'h0, cmd_wdata = 32'h0;
  logic [3:0]  cmd_be = 4'hF;
  logic [10:0] cmd_burst = 11'h001;
  wire logic cmd_ready, rsp_valid, read, write, arbiterlock, flush, resetrequest;
  wire logic waitrequest, readdatavalid;
  wire logic [31:0] rsp_data, address, writedata, readdata;
  wire logic [15:0] rd_pending;
  wire logic [3:0]  byteenable;
  wire logic [10:0] burstcount;
  wire logic [10:0] burstcount_b;
  wire logic        arbiterlock_b;
  logic [31:0] expq[$];
  logic [80:0] cmdq[$];
  int num_errors = 0, tests_run = 0;

  mm_bus_master_ctrl dut (.clock(clock), .reset_n(reset_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_be(cmd_be), .cmd_burst(cmd_burst), .cmd_lock(cmd_lock), .cmd_flush(cmd_flush),
    .sys_reset_req(sys_reset_req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rd_pending(rd_pending), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .burstcount(burstcount),
    .arbiterlock(arbiterlock), .flush(flush), .resetrequest(resetrequest),
    .waitrequest(waitrequest), .readdatavalid(readdatavalid), .readdata(readdata));
  mm_fabric_model fab (.clock(clock), .reset_n(reset_n), .read(read), .write(write),
    .flush(flush), .slow(slow), .address(address), .waitrequest(waitrequest),
    .readdatavalid(readdatavalid), .readdata(readdata));
  // Bursting build on the same inputs: same bus phases, clamped length, never a held grant.
  mm_bus_master_ctrl #(.ENABLE_BURST(1'b1)) dut_b (.clock(clock), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd_ready(), .cmd_read(cmd_read), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_be(cmd_be), .cmd_burst(cmd_burst), .cmd_lock(cmd_lock),
    .cmd_flush(cmd_flush), .sys_reset_req(sys_reset_req), .rsp_valid(), .rsp_data(),
    .rd_pending(), .address(), .read(), .write(), .writedata(), .byteenable(),
    .burstcount(burstcount_b), .arbiterlock(arbiterlock_b), .flush(), .resetrequest(),
    .waitrequest(waitrequest), .readdatavalid(readdatavalid), .readdata(readdata));

  // Clock at 25 MHz.
  always #20 clock = ~clock;

  function automatic logic [31:0] exp_data(input logic [31:0] a);
    return a ^ 32'h5A5A0F0F;
  endfunction

  // Legal burst length: at least one, at most two to the power of width minus one.
  function automatic logic [10:0] exp_burst(input logic [10:0] b);
    if (b == 11'h000) return 11'h001;
    if (b > 11'h400) return 11'h400;
    return b;
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Entered on a rising edge; leaves on the edge that takes the command, valid still up.
  task automatic issue(input logic rd, input logic lk, input logic fl, input logic [31:0] a);
    int n;
    logic [31:0] wd;
    n = 0;
    wd = $urandom;
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_lock <= lk;
    cmd_flush <= fl;
    cmd_addr <= a;
    cmd_wdata <= wd;
    #1;
    while (cmd_ready !== 1'b1 && n < 200) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (cmd_ready !== 1'b1) begin
      check("cmd_ready wait", 32'h0, 32'h1);
      end_of_test();
    end
    @(posedge clock);
    // The bus shows this command from this edge; the monitor checks it when the fabric accepts it.
    cmdq.push_back({cmd_be, cmd_burst, rd, fl, wd, a});
  endtask

  task automatic idle(input int k);
    cmd_valid <= 1'b0;
    repeat (k) @(posedge clock);
  endtask

  // Words must arrive in order and the count must track what is still owed; an accepted
  // transfer is checked against its command and only then changes what is owed.
  always @(negedge clock) begin : bus_mon
    logic [80:0] c;
    c = '0;
    if (reset_n === 1'b1) begin
      if (rsp_valid === 1'b1 && expq.size() == 0) check("extra word", 32'h1, 32'h0);
      else if (rsp_valid === 1'b1) check("rsp_data", rsp_data, expq.pop_front());
      check("rd_pending", rd_pending, 32'(expq.size()));
      if ((read | write) === 1'b1 && waitrequest === 1'b0) begin
        if (cmdq.size() != 0) c = cmdq.pop_front();
        check("address", address, c[31:0]);
        check("bus read", read, c[65]);
        check("bus write", write, !c[65]);
        check("bus flush", flush, c[64]);
        check("byteenable", byteenable, c[80:77]);
        if (c[65] == 1'b0) check("writedata", writedata, c[63:32]);
        check("burstcount", burstcount, 32'h1);
        check("burst build length", burstcount_b, exp_burst(c[76:66]));
        check("burst build lock", arbiterlock_b, 32'h0);
        if (c[64]) expq.delete();
        if (c[65]) expq.push_back(exp_data(c[31:0]));
      end
    end
  end

  initial begin
    void'($urandom(32'h29F1));
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    @(negedge clock);
    check("read", read, 32'h0);
    check("burstcount", burstcount, 32'h1);
    @(posedge clock);
    // Random traffic; flushes land on back-to-back reads as well.
    for (int i = 0; i < 80; i++) begin
      slow <= 1'($urandom);
      cmd_be <= 4'($urandom);
      cmd_burst <= 11'($urandom);
      issue(1'($urandom), 1'b0, $urandom_range(0, 5) == 0, $urandom);
      if (i % 7 == 0) idle(2);
    end
    slow <= 1'b0;
    issue(1'b1, 1'b1, 1'b0, 32'h0000_0100);
    idle(4);
    check("lock held", arbiterlock, 32'h1);
    issue(1'b0, 1'b0, 1'b0, 32'h0000_0104);
    idle(3);
    check("lock freed", arbiterlock, 32'h0);
    // A locked sequence left open must still give the grant back after the idle limit.
    issue(1'b1, 1'b1, 1'b0, 32'h0000_0200);
    idle(250);
    check("lock kept", arbiterlock, 32'h1);
    idle(10);
    check("lock timeout", arbiterlock, 32'h0);
    sys_reset_req <= 1'b1;
    idle(3);
    check("resetrequest", resetrequest, 32'h1);
    sys_reset_req <= 1'b0;
    for (int n = 0; n < 500 && rd_pending !== 16'h0000; n++) @(posedge clock);
    check("drained", rd_pending, 32'h0);
    end_of_test();
  end
endmodule

/* tb/mm_fabric_model.sv */
// Fabric model with random stalls and in-order read returns.
// Assumes a single master on the same bus clock.
module mm_fabric_model (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic        flush,
  input  wire logic        slow,
  input  wire logic [31:0] address,
  output logic             waitrequest,
  output logic             readdatavalid,
  output logic [31:0]      readdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] q[$];

  // A lone master keeps its grant, so lock and priority need no logic.
  always @(posedge clock) begin
    if (!reset_n) begin
      q.delete();
      waitrequest <= 1'b0;
      readdatavalid <= 1'b0;
      readdata <= 32'h0;
    end else begin
      if (busy_take()) begin
        if (flush) q.delete();
        if (read) q.push_back(address ^ 32'h5A5A0F0F);
      end
      waitrequest <= slow & 1'($urandom);
      if (q.size() != 0 && (!slow || 1'($urandom))) begin
        readdatavalid <= 1'b1;
        readdata <= q.pop_front();
      end else begin
        readdatavalid <= 1'b0;
        readdata <= ~readdata; // Idle lines toggle so stale data never looks valid.
      end
    end
  end

  function automatic bit busy_take();
    return (read | write) & ~waitrequest;
  endfunction
endmodule
